// file: shared/apws_defs.vh
// Purpose: Constants for the power and wake sequencer
// Assumes: 200 MHz always-on clock
// Notes: State codes follow the sleep state numbers
`ifndef APWS_DEFS_VH
`define APWS_DEFS_VH

// ****************************************
// Sleep state codes
// ****************************************
`define APWS_S0 3'h0
`define APWS_S1 3'h1
`define APWS_S3 3'h3
`define APWS_S4 3'h4
`define APWS_S5 3'h5
`define APWS_RST_STATE 3'h5

// ****************************************
// Global state codes
// ****************************************
`define APWS_G0 2'h0
`define APWS_G1 2'h1
`define APWS_G2 2'h2

// ****************************************
// Wake source bit positions
// ****************************************
`define APWS_W_SW 0
`define APWS_W_LAN 1
`define APWS_W_RING 2
`define APWS_W_PME 3
`define APWS_W_KBMS 4
`define APWS_W_RTC 5
`define APWS_W_USB 6
`define APWS_W_PCIE 7
`define APWS_NSRC 8
`define APWS_SRC_RST 8'h00

// ****************************************
// Timing
// ****************************************
`define APWS_CLK_HZ 200000000
`define APWS_LONG_PRESS_S 4

`endif

// file: core/apws_seq.v
// Purpose: Power state sequencer with power switch timing and wake gating
// Assumes: Switch and wake inputs are asynchronous pins; settings are on mclk_i
// Notes: Reset leaves the system in soft-off

`include "apws_defs.vh"

// What this block does
// RQ1: A short press in soft-off moves the system to working.
// RQ2: A short press in working moves the system to a sleeping state.
// RQ3: A press held past four seconds in working or sleeping forces soft-off.
// RQ4: A short press in a sleeping state wakes the system to working.
// RQ5: With ACPI on, the operating system commands transitions and the block performs them.
// RQ6: A short press in working enters S3 when the policy input is set, S1 when it is clear.
// RQ7: Switch, RTC alarm and express-bus wake may wake from S1, S3, S4 and S5.
// RQ8: Network and conventional-bus wake work from S1, S3, S4, and from S5 only when enabled.
// RQ9: With the power-on option set, a network wake in S5 is a valid wake.
// RQ10: Modem ring, keyboard/mouse and USB wake only from S1 or S3.
// RQ11: In S3, S4 and S5 devices sit in D3 unpowered while wake logic stays powered.
// RQ12: Leaving S5 starts a cold boot, leaving S3 or S4 restores saved context.
// RQ13: The conventional-bus event wakes only when wake on event is enabled.
// RQ14: The express-bus wake starts a wake from any sleep state.
// RQ15: A counter on the always-on clock times the press and fires the long action at threshold.
module apws_seq #(
    parameter [31:0] LONG_CYC = `APWS_LONG_PRESS_S * `APWS_CLK_HZ
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // Front panel switch, active low
    input wire pwr_sw_n_i,
    // Wake sources from pins
    input wire lan_wake_i,
    input wire ring_i,
    input wire pme_n_i,
    input wire kbms_i,
    input wire rtc_alarm_i,
    input wire usb_i,
    input wire pcie_wake_n_i,
    // Firmware settings
    input wire acpi_en_i,
    input wire sw_sleep_pol_i,
    input wire lan_s5_en_i,
    input wire pme_en_i,
    input wire pme_s5_en_i,
    // Operating system command
    input wire os_req_i,
    input wire [2:0] os_state_i,
    // Power state outputs
    output reg [2:0] sstate_o,
    output reg [1:0] gstate_o,
    output reg main_pwr_o,
    output reg dev_d3_o,
    output reg wake_logic_pwr_o,
    output reg cold_boot_o,
    output reg resume_o,
    output reg wake_evt_o,
    output reg os_ack_o
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    wire [`APWS_NSRC-1:0] raw_w;
    reg [`APWS_NSRC-1:0] sync1_r;
    reg [`APWS_NSRC-1:0] sync2_r;
    reg [`APWS_NSRC-1:0] sync3_r;
    reg [`APWS_NSRC-1:0] filt_r;
    reg [`APWS_NSRC-1:0] filt_d_r;

    assign raw_w[`APWS_W_SW] = ~pwr_sw_n_i;
    assign raw_w[`APWS_W_LAN] = lan_wake_i;
    assign raw_w[`APWS_W_RING] = ring_i;
    assign raw_w[`APWS_W_PME] = ~pme_n_i;
    assign raw_w[`APWS_W_KBMS] = kbms_i;
    assign raw_w[`APWS_W_RTC] = rtc_alarm_i;
    assign raw_w[`APWS_W_USB] = usb_i;
    assign raw_w[`APWS_W_PCIE] = ~pcie_wake_n_i;

    genvar gi;
    generate
        for (gi = 0; gi < `APWS_NSRC; gi = gi + 1) begin : g_sync
            always @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                    filt_r[gi] <= 1'b0;
                    filt_d_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= raw_w[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        filt_r[gi] <= sync3_r[gi];
                    end
                    filt_d_r[gi] <= filt_r[gi];
                end
            end
        end
    endgenerate

    wire [`APWS_NSRC-1:0] rise_w;
    assign rise_w = filt_r & ~filt_d_r;

    wire sw_on_w;
    wire sw_rel_w;
    assign sw_on_w = filt_r[`APWS_W_SW];
    assign sw_rel_w = filt_d_r[`APWS_W_SW] & ~filt_r[`APWS_W_SW];

    // ****************************************
    // Press timer
    // ****************************************
    reg [31:0] press_cnt_r;
    reg long_done_r;
    reg long_fire_r;
    reg short_fire_r;

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            press_cnt_r <= 32'h00000000;
            long_done_r <= 1'b0;
            long_fire_r <= 1'b0;
            short_fire_r <= 1'b0;
        end else begin
            long_fire_r <= 1'b0;
            short_fire_r <= 1'b0;
            if (sw_on_w) begin
                if (press_cnt_r != LONG_CYC) begin
                    press_cnt_r <= press_cnt_r + 32'h00000001; // RQ15
                end
                if (press_cnt_r == LONG_CYC - 32'h00000001 && !long_done_r) begin
                    long_fire_r <= 1'b1; // RQ15
                    long_done_r <= 1'b1;
                end
            end else begin
                press_cnt_r <= 32'h00000000;
                long_done_r <= 1'b0;
                if (sw_rel_w && !long_done_r) begin
                    short_fire_r <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Wake gating
    // ****************************************
    reg [`APWS_NSRC-1:0] wake_ok;

    always @* begin
        wake_ok = `APWS_SRC_RST;
        case (sstate_o)
            `APWS_S1, `APWS_S3: begin
                wake_ok[`APWS_W_RTC] = 1'b1; // RQ7
                wake_ok[`APWS_W_PCIE] = 1'b1; // RQ14
                wake_ok[`APWS_W_LAN] = 1'b1; // RQ8
                wake_ok[`APWS_W_PME] = pme_en_i; // RQ13
                wake_ok[`APWS_W_RING] = 1'b1; // RQ10
                wake_ok[`APWS_W_KBMS] = 1'b1; // RQ10
                wake_ok[`APWS_W_USB] = 1'b1; // RQ10
            end
            `APWS_S4: begin
                wake_ok[`APWS_W_RTC] = 1'b1; // RQ7
                wake_ok[`APWS_W_PCIE] = 1'b1; // RQ14
                wake_ok[`APWS_W_LAN] = 1'b1; // RQ8
                wake_ok[`APWS_W_PME] = pme_en_i; // RQ13
            end
            `APWS_S5: begin
                wake_ok[`APWS_W_RTC] = 1'b1; // RQ7
                wake_ok[`APWS_W_PCIE] = 1'b1; // RQ14
                wake_ok[`APWS_W_LAN] = lan_s5_en_i; // RQ9
                wake_ok[`APWS_W_PME] = pme_en_i & pme_s5_en_i; // RQ8
            end
            default: begin
                wake_ok = `APWS_SRC_RST;
            end
        endcase
    end

    wire src_wake_w;
    assign src_wake_w = |(rise_w & wake_ok & ~(8'h01 << `APWS_W_SW));

    // ****************************************
    // State sequencer
    // ****************************************
    wire is_sleep_w;
    wire os_ok_w;
    assign is_sleep_w = (sstate_o == `APWS_S1) || (sstate_o == `APWS_S3) ||
                        (sstate_o == `APWS_S4) || (sstate_o == `APWS_S5);
    assign os_ok_w = acpi_en_i && os_req_i && (sstate_o == `APWS_S0) &&
                     ((os_state_i == `APWS_S1) || (os_state_i == `APWS_S3) ||
                      (os_state_i == `APWS_S4) || (os_state_i == `APWS_S5));

    reg [2:0] state_nxt;
    reg wake_nxt;
    reg ack_nxt;

    always @* begin
        state_nxt = sstate_o;
        wake_nxt = 1'b0;
        ack_nxt = 1'b0;
        if (long_fire_r && sstate_o != `APWS_S5) begin
            state_nxt = `APWS_S5; // RQ3
        end else if (os_ok_w) begin
            state_nxt = os_state_i; // RQ5
            ack_nxt = 1'b1;
        end else if (short_fire_r) begin
            case (sstate_o)
                `APWS_S0: begin
                    if (sw_sleep_pol_i) begin
                        state_nxt = `APWS_S3; // RQ6
                    end else begin
                        state_nxt = `APWS_S1; // RQ2
                    end
                end
                `APWS_S5: begin
                    state_nxt = `APWS_S0; // RQ1
                    wake_nxt = 1'b1;
                end
                `APWS_S1, `APWS_S3, `APWS_S4: begin
                    state_nxt = `APWS_S0; // RQ4
                    wake_nxt = 1'b1;
                end
                default: begin
                    state_nxt = `APWS_S5;
                end
            endcase
        end else if (is_sleep_w && src_wake_w) begin
            state_nxt = `APWS_S0; // RQ7
            wake_nxt = 1'b1;
        end
    end

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sstate_o <= `APWS_RST_STATE;
            gstate_o <= `APWS_G2;
            main_pwr_o <= 1'b0;
            dev_d3_o <= 1'b1;
            wake_logic_pwr_o <= 1'b1;
            cold_boot_o <= 1'b0;
            resume_o <= 1'b0;
            wake_evt_o <= 1'b0;
            os_ack_o <= 1'b0;
        end else begin
            sstate_o <= state_nxt;
            wake_evt_o <= wake_nxt;
            os_ack_o <= ack_nxt;
            wake_logic_pwr_o <= 1'b1; // RQ11
            cold_boot_o <= wake_nxt && (sstate_o == `APWS_S5); // RQ12
            resume_o <= wake_nxt && ((sstate_o == `APWS_S3) ||
                                     (sstate_o == `APWS_S4)); // RQ12
            case (state_nxt)
                `APWS_S0: begin
                    gstate_o <= `APWS_G0;
                    main_pwr_o <= 1'b1;
                    dev_d3_o <= 1'b0;
                end
                `APWS_S1: begin
                    gstate_o <= `APWS_G1;
                    main_pwr_o <= 1'b1;
                    dev_d3_o <= 1'b0;
                end
                `APWS_S3, `APWS_S4: begin
                    gstate_o <= `APWS_G1;
                    main_pwr_o <= 1'b0;
                    dev_d3_o <= 1'b1; // RQ11
                end
                default: begin
                    gstate_o <= `APWS_G2;
                    main_pwr_o <= 1'b0;
                    dev_d3_o <= 1'b1; // RQ11
                end
            endcase
        end
    end

endmodule

// file: verification/apws_seq_asserts.sv
// Purpose: Port checks for the power and wake sequencer
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to apws_seq after the module
`include "apws_defs.vh"
module apws_seq_asserts #(parameter [31:0] LONG_CYC = 32'h14) (
    // Clock, reset and pins
    input logic mclk_i, rst_n_i, pwr_sw_n_i, ring_i, kbms_i, usb_i,
    input logic rtc_alarm_i, pcie_wake_n_i, acpi_en_i, os_req_i,
    input logic [2:0] os_state_i, sstate_o,
    input logic [1:0] gstate_o,
    // Levels and pulses
    input logic main_pwr_o, dev_d3_o, wake_logic_pwr_o, cold_boot_o,
    input logic resume_o, wake_evt_o, os_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] low_r;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Cycles the switch pin has been held low
    always @(posedge mclk_i) low_r <= (!rst_n_i || pwr_sw_n_i) ? 32'h0 : low_r + 32'h1;
    sequence rel_s5; sstate_o == `APWS_S5 && $rose(pwr_sw_n_i) &&
        low_r > 32'h1 && low_r + 32'h4 < LONG_CYC; endsequence
    sequence wk_all; $fell(pcie_wake_n_i) || $rose(rtc_alarm_i); endsequence
    sequence wk_low; $rose(ring_i) || $rose(kbms_i) || $rose(usb_i); endsequence
    aon_pwr_a: assert property (wake_logic_pwr_o) else $error("wake power");
    d3_map_a: assert property (dev_d3_o == (sstate_o >= `APWS_S3)) else $error("d3");
    main_map_a: assert property (main_pwr_o == (sstate_o <= `APWS_S1)) else $error("pwr");
    g_map_a: assert property (gstate_o == (sstate_o == `APWS_S0 ? `APWS_G0 :
        sstate_o == `APWS_S5 ? `APWS_G2 : `APWS_G1)) else $error("gstate");
    os_cmd_a: assert property (os_req_i && acpi_en_i && sstate_o == `APWS_S0 &&
        os_state_i inside {3'h1, 3'h3, 3'h4, 3'h5} |=> os_ack_o && sstate_o == $past(os_state_i))
        else $error("os cmd");
    ack_src_a: assert property (os_ack_o |-> $past(os_req_i) && $past(acpi_en_i))
        else $error("ack");
    cold_a: assert property (cold_boot_o |-> wake_evt_o && $past(sstate_o) == `APWS_S5)
        else $error("cold");
    resume_a: assert property (resume_o |-> sstate_o == `APWS_S0 &&
        $past(sstate_o) inside {3'h3, 3'h4}) else $error("resume");
    short_on_a: assert property (rel_s5 |-> ##[4:8] sstate_o == `APWS_S0 && wake_evt_o)
        else $error("short on");
    any_wake_a: assert property (sstate_o != `APWS_S0 ##0 wk_all |-> ##[3:7]
        sstate_o == `APWS_S0) else $error("wake");
    low_src_a: assert property (sstate_o >= `APWS_S4 ##0 wk_low |=> $stable(sstate_o)[*8])
        else $error("low wake");
    long_a: assert property (low_r == LONG_CYC + 32'h8 |-> sstate_o == `APWS_S5)
        else $error("long");
endmodule
bind apws_seq apws_seq_asserts #(.LONG_CYC(LONG_CYC)) u_chk (.*);

// file: verification/apws_panel.sv
// Purpose: Front panel, wake sources and operating system
// Assumes: Calls start just after a rising edge
// Notes: Wake lines are active high here
module apws_panel (
    input logic mclk_i,
    output logic sw_n_o = 1'b1,
    output logic [7:0] src_o = 8'h00,
    output logic os_req_o = 1'b0,
    output logic [2:0] os_state_o = 3'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // Hold the switch for n cycles
    task automatic press(input int n);
        sw_n_o = 1'b0;
        cyc(n);
        sw_n_o = 1'b1;
        cyc(12);
    endtask
    // Raise one wake line for 8 cycles
    task automatic poke(input int b);
        src_o[b] = 1'b1;
        cyc(8);
        src_o[b] = 1'b0;
        cyc(12);
    endtask
    // One-cycle command; code scrambled when not qualified
    task automatic os_cmd(input logic [2:0] s);
        os_req_o = 1'b1;
        os_state_o = s;
        cyc(1);
        os_req_o = 1'b0;
        os_state_o = ~s;
        cyc(4);
    endtask
endmodule

// file: verification/test_apws_seq.sv
// Purpose: Self-checking bench for the power and wake sequencer
// Assumes: Long press count shortened to 20 cycles
// Notes: Every state change is matched against a queue
`include "apws_defs.vh"
module test_apws_seq;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [31:0] LC = 32'h14;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, acpi_en_i = 1'b1, sw_sleep_pol_i = 1'b0;
    logic lan_s5_en_i = 1'b0, pme_en_i = 1'b0, pme_s5_en_i = 1'b0, ok;
    logic pwr_sw_n_i, lan_wake_i, ring_i, pme_n_i, kbms_i, rtc_alarm_i, usb_i, pcie_wake_n_i;
    logic os_req_i, main_pwr_o, dev_d3_o, wake_logic_pwr_o, cold_boot_o, resume_o;
    logic wake_evt_o, os_ack_o;
    logic [1:0] gstate_o;
    logic [2:0] os_state_i, sstate_o, prev, cur = `APWS_S5;
    logic [2:0] st[4] = '{3'h1, 3'h3, 3'h4, 3'h5};
    logic [7:0] src;
    logic [6:0] expq[$];
    logic [6:0] note;
    int error_cnt = 0, n_checks = 0, seed = 2;
    always #2.5 mclk_i = ~mclk_i;
    assign {usb_i, rtc_alarm_i, kbms_i, ring_i, lan_wake_i} = {src[6:4], src[2:1]};
    assign pme_n_i = ~src[3];
    assign pcie_wake_n_i = ~src[7];
    apws_seq #(.LONG_CYC(LC)) u_dut (.*);
    apws_panel u_pnl (.mclk_i(mclk_i), .sw_n_o(pwr_sw_n_i), .src_o(src), .os_req_o(os_req_i),
        .os_state_o(os_state_i));
    task automatic fail(input string m);
        error_cnt++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk_tr(input logic [6:0] e, input logic [6:0] g);
        n_checks++;
        if (g !== e) fail($sformatf("change %h, wanted %h", g, e));
    endtask
    task automatic chk_lvl(input logic [2:0] s, input logic [4:0] g);
        logic [4:0] e;
        e = {(s == `APWS_S0) ? `APWS_G0 : (s == `APWS_S5) ? `APWS_G2 : `APWS_G1,
            s <= `APWS_S1, s >= `APWS_S3, 1'b1};
        n_checks++;
        if (g !== e) fail($sformatf("levels %h, wanted %h", g, e));
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Monitor: each state change takes the oldest note
    always @(negedge mclk_i) begin
        if (!rst_n_i) begin
            prev <= `APWS_RST_STATE;
        end else if (sstate_o !== prev) begin
            prev <= sstate_o;
            if (expq.size() == 0) fail("change not expected");
            else begin
                note = expq.pop_front();
                chk_tr(note, {sstate_o, wake_evt_o, cold_boot_o, resume_o, os_ack_o});
                chk_lvl(note[6:4], {gstate_o, main_pwr_o, dev_d3_o, wake_logic_pwr_o});
            end
        end
    end
    // Note: state, then wake, cold boot, resume, ack
    task automatic ex(input logic [2:0] s, input logic [3:0] f);
        expq.push_back({s, f});
        cur = s;
    endtask
    task automatic done();
        n_checks++;
        if (expq.size() != 0) fail("change missing");
        expq.delete();
    endtask
    task automatic to_on();
        ex(`APWS_S0, {1'b1, cur == `APWS_S5, cur == `APWS_S3 || cur == `APWS_S4, 1'b0});
    endtask
    task automatic tap();
        if (cur == `APWS_S0) ex(sw_sleep_pol_i ? `APWS_S3 : `APWS_S1, 4'h0);
        else to_on();
        u_pnl.press(5);
        done();
    endtask
    task automatic wake(input int b, input logic w);
        if (w) to_on();
        u_pnl.poke(b);
        done();
    endtask
    initial begin
        repeat (12) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        u_pnl.cyc(6);
        tap();
        tap();
        tap();
        sw_sleep_pol_i = 1'b1;
        tap();
        ex(`APWS_S5, 4'h0);
        u_pnl.press(LC + 15);
        done();
        tap();
        ex(`APWS_S5, 4'h0);
        u_pnl.press(LC + 15);
        done();
        tap();
        acpi_en_i = 1'b0;
        u_pnl.os_cmd(`APWS_S3);
        acpi_en_i = 1'b1;
        u_pnl.os_cmd(3'h2);
        done();
        for (int s = 0; s < 4; s++) begin
            for (int b = 1; b < 8; b++) begin
                {lan_s5_en_i, pme_en_i, pme_s5_en_i} = 3'($random(seed));
                if (cur != `APWS_S0) tap();
                ex(st[s], 4'h1);
                u_pnl.os_cmd(st[s]);
                done();
                case (b)
                    1: ok = st[s] != `APWS_S5 || lan_s5_en_i;
                    3: ok = pme_en_i && (st[s] != `APWS_S5 || pme_s5_en_i);
                    5, 7: ok = 1'b1;
                    default: ok = st[s] <= `APWS_S3;
                endcase
                wake(b, ok);
            end
        end
        if (cur != `APWS_S0) tap();
        wake(7, 1'b0);
        end_sim();
    end
    initial begin
        #100us;
        fail("watchdog expired");
        end_sim();
    end
endmodule
